//--- eas_pkg.sv
package eas_pkg;

	localparam logic [7:0] OP_SET_EAS = 8'hA2;
	localparam logic [7:0] OP_RESET_EAS = 8'hA3;
	localparam logic [7:0] OP_LOCK_EAS = 8'hA4;
	localparam logic [7:0] OP_ACTIVE_EAS = 8'hA5;
	localparam logic [7:0] OP_PROTECT_EAS = 8'hA6;
	localparam logic [7:0] OP_WRITE_IDENT = 8'hA7;
	localparam logic [7:0] OP_WRITE_LENGTH = 8'hA8;

	localparam logic [7:0] FLAGS_OK = 8'h00;
	localparam logic [7:0] FLAGS_ERROR = 8'h01;
	localparam logic [7:0] ERR_NOT_SECURE = 8'h0F;
	localparam logic [7:0] ERR_LOCKED = 8'h12;

	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_BYTE = 8'h08;
	localparam logic [7:0] MASK_WORD = 8'h10;

	localparam int CLOCK_MHZ = 25;
	localparam int T_PROG_US = 5000;
	localparam int PROG_CYCLES_DEF = T_PROG_US * CLOCK_MHZ;
	localparam int CNT_W = 20;

	localparam logic [3:0] NUM_TELE_BLOCKS = 4'h8;
	localparam logic [8:0] BLOCK_BITS = 9'h020;
	localparam logic [8:0] IDENT_BITS = 9'h010;
	localparam logic [8:0] FLAGS_ONLY_BITS = 9'h000;
	localparam logic [8:0] ERROR_BITS = 9'h008;
	localparam logic [1:0] LEN_RESET = 2'h0;
	localparam logic [15:0] IDENT_RESET = 16'h0000;
	localparam logic [31:0] TELE_RESET = 32'h00000000;

	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_IDENT = 4'h1;
	localparam logic [3:0] REG_TELE_BASE = 4'h2;
	localparam logic [3:0] REG_TELE_LAST = 4'h9;

	localparam int ST_EAS_SET = 0;
	localparam int ST_LOCKED = 1;
	localparam int ST_PROTECTED = 2;
	localparam int ST_LEN_LO = 4;
	localparam int ST_BUSY = 8;

	typedef enum logic [1:0] {
		RESP_FLAGS,
		RESP_ERROR,
		RESP_TELEGRAM,
		RESP_IDENT
	} resp_kind_e;

	typedef enum logic [1:0] {
		FSM_IDLE,
		FSM_PROGRAM,
		FSM_WAIT_EOF
	} fsm_e;

	typedef struct packed {
		logic [7:0] opcode;
		logic option;
		logic secure;
		logic [7:0] mask_len;
		logic [15:0] mask_val;
		logic [15:0] param;
	} req_s;

	typedef struct packed {
		resp_kind_e kind;
		logic [7:0] flags;
		logic [7:0] code;
		logic [8:0] bits;
		logic [255:0] payload;
	} resp_s;

	// First telegram slot inside blocks 24..31 for each length selector
	function automatic logic [3:0] tele_start(input logic [1:0] sel);
		case (sel)
			2'h0: tele_start = 4'h0;
			2'h1: tele_start = 4'h4;
			2'h2: tele_start = 4'h6;
			default: tele_start = 4'h7;
		endcase
	endfunction

endpackage

//--- eas_custom_command_handler.sv
// Function
// - Lock freezes surveillance state and identifier
// - Lock needs secure mode when protected
// - Option clear: reply after programming time
// - Option set: reply on separate EOF
// - Active request ignored while surveillance reset
// - Active general reply: flags plus telegram
// - Active request errors stay silent
// - Selective nonzero mask: reply only on match
// - Zero mask: reply flags plus identifier
// - Telegram read from start block to 31
// - Delivered: zero telegram, full 256-bit length
// - Telegram uses latest single-block written contents
// - Protect enables password, secure mode only
// - Write identifier, secure when protected, 16 bits
// - Length write keeps two low bits
// - Selector decodes to 256/128/64/32 bits
// - Length write needs secure when protected
// - General active request has no identifier fields
// - Set surveillance unless locked, else error
// - Reset surveillance unless locked, else error
`timescale 1ns/1ps
`default_nettype none
module eas_custom_command_handler #(
	parameter int PROG_CYCLES = eas_pkg::PROG_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire eas_pkg::req_s req,
	input wire logic eof_pulse,
	output logic resp_valid,
	output eas_pkg::resp_s resp,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	typedef struct packed {
		eas_pkg::fsm_e fsm;
		logic [eas_pkg::CNT_W-1:0] cnt;
		eas_pkg::req_s pend;
		logic eas_set;
		logic locked;
		logic protect;
		logic [15:0] ident;
		logic [1:0] len_sel;
		logic [7:0][31:0] tele;
		logic resp_valid;
		eas_pkg::resp_s resp;
		logic wait_n;
		logic waitreq;
		logic [31:0] rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	localparam logic [eas_pkg::CNT_W-1:0] CNT_LAST =
		eas_pkg::CNT_W'(PROG_CYCLES - 1);

	logic accept;
	logic [3:0] start;
	logic [7:0][31:0] slot;
	logic [8:0] tele_bits;
	logic need_secure;
	logic bad_secure;
	logic bad_lock;
	logic is_write_op;
	logic ident_match;
	logic mask_ok;
	logic bus_req;
	logic [3:0] tele_idx;

	assign accept = req_valid && (s_q.fsm == eas_pkg::FSM_IDLE);
	assign start = eas_pkg::tele_start(s_q.len_sel);
	assign tele_bits = 9'((eas_pkg::NUM_TELE_BLOCKS - start)
		* eas_pkg::BLOCK_BITS);
	assign bus_req = avs_read || avs_write;
	assign tele_idx = avs_address - eas_pkg::REG_TELE_BASE;

	// Slot 0 of the payload holds the start block, upward to block 31
	genvar j;
	generate
		for (j = 0; j < 8; j++) begin : g_slot
			logic [3:0] idx;
			assign idx = start + 4'(j);
			assign slot[j] = (idx < eas_pkg::NUM_TELE_BLOCKS) ?
				s_q.tele[idx[2:0]] : eas_pkg::TELE_RESET;
		end
	endgenerate

	assign is_write_op = (req.opcode == eas_pkg::OP_SET_EAS) ||
		(req.opcode == eas_pkg::OP_RESET_EAS) ||
		(req.opcode == eas_pkg::OP_LOCK_EAS) ||
		(req.opcode == eas_pkg::OP_PROTECT_EAS) ||
		(req.opcode == eas_pkg::OP_WRITE_IDENT) ||
		(req.opcode == eas_pkg::OP_WRITE_LENGTH);
	assign need_secure = (req.opcode == eas_pkg::OP_PROTECT_EAS) ||
		s_q.protect;
	assign bad_secure = need_secure && !req.secure;
	// A locked state also freezes the identifier
	assign bad_lock = s_q.locked &&
		((req.opcode == eas_pkg::OP_SET_EAS) ||
		(req.opcode == eas_pkg::OP_RESET_EAS) ||
		(req.opcode == eas_pkg::OP_WRITE_IDENT));

	// Mask lengths other than 0, 8 or 16 count as errors
	always_comb begin
		mask_ok = 1'b1;
		ident_match = 1'b0;
		case (req.mask_len)
			eas_pkg::MASK_NONE: ident_match = 1'b1;
			eas_pkg::MASK_BYTE:
				ident_match = (req.mask_val[7:0] == s_q.ident[7:0]);
			eas_pkg::MASK_WORD: ident_match = (req.mask_val == s_q.ident);
			default: mask_ok = 1'b0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.resp_valid = 1'b0;

		// Bus slave: one wait cycle, then a single answer cycle
		s_d.wait_n = bus_req && !s_q.wait_n;
		s_d.waitreq = !s_d.wait_n;
		if (bus_req && !s_q.wait_n) begin
			s_d.rdata = '0;
			case (avs_address)
				eas_pkg::REG_STATUS: begin
					s_d.rdata[eas_pkg::ST_EAS_SET] = s_q.eas_set;
					s_d.rdata[eas_pkg::ST_LOCKED] = s_q.locked;
					s_d.rdata[eas_pkg::ST_PROTECTED] = s_q.protect;
					s_d.rdata[eas_pkg::ST_LEN_LO +: 2] = s_q.len_sel;
					s_d.rdata[eas_pkg::ST_BUSY] =
						(s_q.fsm != eas_pkg::FSM_IDLE);
				end
				eas_pkg::REG_IDENT: s_d.rdata[15:0] = s_q.ident;
				default: begin
					if (avs_address >= eas_pkg::REG_TELE_BASE &&
						avs_address <= eas_pkg::REG_TELE_LAST) begin
						s_d.rdata = s_q.tele[tele_idx[2:0]];
					end
				end
			endcase
		end
		// Single-block write into blocks 24..31 takes effect on the answer
		if (avs_write && s_q.wait_n &&
			avs_address >= eas_pkg::REG_TELE_BASE &&
			avs_address <= eas_pkg::REG_TELE_LAST) begin
			for (int b = 0; b < 4; b++) begin
				if (avs_byteenable[b]) begin
					s_d.tele[tele_idx[2:0]][b*8 +: 8] =
						avs_writedata[b*8 +: 8];
				end
			end
		end

		case (s_q.fsm)
			eas_pkg::FSM_IDLE: begin
				s_d.cnt = '0;
				if (accept && req.opcode == eas_pkg::OP_ACTIVE_EAS) begin
					s_d.resp.flags = eas_pkg::FLAGS_OK;
					s_d.resp.code = eas_pkg::FLAGS_OK;
					// Errors and a reset state both give silence
					if (s_q.eas_set) begin
						if (!req.option) begin
							s_d.resp_valid = 1'b1;
							s_d.resp.kind = eas_pkg::RESP_TELEGRAM;
							s_d.resp.bits = tele_bits;
							s_d.resp.payload = slot;
						end else if (mask_ok &&
							req.mask_len == eas_pkg::MASK_NONE) begin
							s_d.resp_valid = 1'b1;
							s_d.resp.kind = eas_pkg::RESP_IDENT;
							s_d.resp.bits = eas_pkg::IDENT_BITS;
							s_d.resp.payload = 256'(s_q.ident);
						end else if (mask_ok && ident_match) begin
							s_d.resp_valid = 1'b1;
							s_d.resp.kind = eas_pkg::RESP_TELEGRAM;
							s_d.resp.bits = tele_bits;
							s_d.resp.payload = slot;
						end
					end
				end else if (accept && is_write_op) begin
					if (bad_secure || bad_lock) begin
						s_d.resp_valid = 1'b1;
						s_d.resp.kind = eas_pkg::RESP_ERROR;
						s_d.resp.flags = eas_pkg::FLAGS_ERROR;
						s_d.resp.code = bad_secure ?
							eas_pkg::ERR_NOT_SECURE : eas_pkg::ERR_LOCKED;
						s_d.resp.bits = eas_pkg::ERROR_BITS;
						s_d.resp.payload = '0;
					end else begin
						s_d.pend = req;
						s_d.fsm = req.option ? eas_pkg::FSM_WAIT_EOF :
							eas_pkg::FSM_PROGRAM;
					end
				end
			end
			eas_pkg::FSM_PROGRAM: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_LAST) begin
					s_d.fsm = eas_pkg::FSM_IDLE;
				end
			end
			eas_pkg::FSM_WAIT_EOF: begin
				if (eof_pulse) begin
					s_d.fsm = eas_pkg::FSM_IDLE;
				end
			end
			default: s_d.fsm = eas_pkg::FSM_IDLE;
		endcase

		// Commit the nonvolatile change together with its reply
		if (s_q.fsm != eas_pkg::FSM_IDLE &&
			s_d.fsm == eas_pkg::FSM_IDLE) begin
			s_d.resp_valid = 1'b1;
			s_d.resp.kind = eas_pkg::RESP_FLAGS;
			s_d.resp.flags = eas_pkg::FLAGS_OK;
			s_d.resp.code = eas_pkg::FLAGS_OK;
			s_d.resp.bits = eas_pkg::FLAGS_ONLY_BITS;
			s_d.resp.payload = '0;
			case (s_q.pend.opcode)
				eas_pkg::OP_SET_EAS: s_d.eas_set = 1'b1;
				eas_pkg::OP_RESET_EAS: s_d.eas_set = 1'b0;
				eas_pkg::OP_LOCK_EAS: s_d.locked = 1'b1;
				eas_pkg::OP_PROTECT_EAS: s_d.protect = 1'b1;
				eas_pkg::OP_WRITE_IDENT:
					s_d.ident = s_q.pend.param;
				eas_pkg::OP_WRITE_LENGTH:
					s_d.len_sel = s_q.pend.param[1:0];
				default: s_d.resp_valid = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.fsm <= eas_pkg::FSM_IDLE;
			s_q.ident <= eas_pkg::IDENT_RESET;
			s_q.len_sel <= eas_pkg::LEN_RESET;
			s_q.tele <= '0;
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign resp_valid = s_q.resp_valid;
	assign resp = s_q.resp;
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_active_req;
		accept && req.opcode == eas_pkg::OP_ACTIVE_EAS;
	endsequence

	sequence s_write_req;
		accept && is_write_op && !bad_secure && !bad_lock;
	endsequence

	chk_lock_frozen: assert property (
		s_q.locked |=> s_q.locked && $stable(s_q.eas_set) &&
			$stable(s_q.ident))
		else $error("locked surveillance state changed");

	chk_lock_secure: assert property (
		accept && req.opcode == eas_pkg::OP_LOCK_EAS && s_q.protect &&
			!req.secure |=> resp_valid &&
			resp.code == eas_pkg::ERR_NOT_SECURE)
		else $error("lock accepted outside secure mode");

	chk_prog_wait: assert property (
		s_write_req ##0 !req.option |=> !resp_valid throughout
			(s_q.fsm == eas_pkg::FSM_PROGRAM)[*2])
		else $error("programming reply came early");

	chk_prog_end: assert property (
		s_q.fsm == eas_pkg::FSM_PROGRAM && s_q.cnt == CNT_LAST |=>
			resp_valid && s_q.fsm == eas_pkg::FSM_IDLE)
		else $error("programming reply missing at end of time");

	chk_eof_reply: assert property (
		s_q.fsm == eas_pkg::FSM_WAIT_EOF |=> resp_valid == $past(eof_pulse))
		else $error("reply not tied to the eof");

	chk_active_silent: assert property (
		s_active_req ##0 !s_q.eas_set |=> !resp_valid [*2])
		else $error("active request answered while reset");

	chk_telegram_len: assert property (
		resp_valid && resp.kind == eas_pkg::RESP_TELEGRAM |->
			resp.bits == 9'(32 * (8 - int'(start))))
		else $error("telegram length wrong");

	chk_mask_zero: assert property (
		s_active_req ##0 s_q.eas_set && req.option &&
			req.mask_len == eas_pkg::MASK_NONE |=> resp_valid &&
			resp.kind == eas_pkg::RESP_IDENT &&
			resp.payload[15:0] == $past(s_q.ident))
		else $error("identifier reply wrong");

	chk_mask_miss: assert property (
		s_active_req ##0 req.option && req.mask_len == eas_pkg::MASK_WORD &&
			req.mask_val != s_q.ident |=> !resp_valid)
		else $error("selective reply without match");

	chk_length_bits: assert property (
		s_q.fsm != eas_pkg::FSM_IDLE &&
			s_q.pend.opcode == eas_pkg::OP_WRITE_LENGTH &&
			s_d.fsm == eas_pkg::FSM_IDLE |=>
			s_q.len_sel == $past(s_q.pend.param[1:0]))
		else $error("length selector not stored");

	chk_set_locked: assert property (
		accept && req.opcode == eas_pkg::OP_SET_EAS && s_q.locked &&
			!bad_secure |=> resp_valid && resp.code == eas_pkg::ERR_LOCKED
			&& resp.flags == eas_pkg::FLAGS_ERROR)
		else $error("set accepted while locked");

	chk_reset_locked: assert property (
		accept && req.opcode == eas_pkg::OP_RESET_EAS &&
			s_q.locked && !bad_secure |=> resp_valid &&
			resp.code == eas_pkg::ERR_LOCKED &&
			resp.flags == eas_pkg::FLAGS_ERROR)
		else $error("reset accepted while locked");

	chk_protect_secure: assert property (
		accept && req.opcode == eas_pkg::OP_PROTECT_EAS &&
			!req.secure |=> resp_valid &&
			resp.code == eas_pkg::ERR_NOT_SECURE)
		else $error("protect accepted outside secure mode");

	chk_ident_secure: assert property (
		accept && req.opcode == eas_pkg::OP_WRITE_IDENT &&
			s_q.protect && !req.secure |=> resp_valid &&
			resp.code == eas_pkg::ERR_NOT_SECURE)
		else $error("identifier write accepted outside secure mode");

	chk_ident_stored: assert property (
		s_q.fsm != eas_pkg::FSM_IDLE &&
			s_q.pend.opcode == eas_pkg::OP_WRITE_IDENT &&
			s_d.fsm == eas_pkg::FSM_IDLE |=>
			s_q.ident == $past(s_q.pend.param))
		else $error("identifier not stored");

	chk_length_secure: assert property (
		accept && req.opcode == eas_pkg::OP_WRITE_LENGTH &&
			s_q.protect && !req.secure |=> resp_valid &&
			resp.code == eas_pkg::ERR_NOT_SECURE)
		else $error("length write accepted outside secure mode");

	chk_general_reply: assert property (
		s_active_req ##0 s_q.eas_set && !req.option |=> resp_valid &&
			resp.kind == eas_pkg::RESP_TELEGRAM &&
			resp.flags == eas_pkg::FLAGS_OK)
		else $error("general active request not answered");

	chk_bad_mask: assert property (
		s_active_req ##0 req.option && req.mask_len != eas_pkg::MASK_NONE &&
			req.mask_len != eas_pkg::MASK_BYTE &&
			req.mask_len != eas_pkg::MASK_WORD |=> !resp_valid)
		else $error("active request with bad mask answered");

	chk_first_block: assert property (
		resp_valid && resp.kind == eas_pkg::RESP_TELEGRAM |->
			resp.payload[31:0] == $past(s_q.tele[start[2:0]]))
		else $error("telegram does not open at the start block");

	// Bus answers after exactly one wait cycle and drops again
	chk_bus_answer: assert property (
		bus_req && avs_waitrequest |=>
			!avs_waitrequest ##1 avs_waitrequest)
		else $error("register bus answer timing wrong");

endmodule
`default_nettype wire

//--- eas_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module eas_reader_model (
	input wire logic clock,
	output logic req_valid,
	output eas_pkg::req_s req,
	output logic eof_pulse,
	input wire logic resp_valid,
	input wire eas_pkg::resp_s resp
);
	// Edges from the take edge to the reply; 0 means the tag stayed silent
	int lat;
	eas_pkg::resp_s got;
	initial begin
		req_valid = 1'b0;
		req = '0;
		eof_pulse = 1'b0;
		lat = 0;
		got = '0;
	end
	// The gap sets how long the reader lets the tag program before its EOF
	task automatic send(input logic [7:0] op, input logic opt,
		input logic sec, input logic [7:0] ml, input logic [15:0] mv,
		input logic [15:0] prm, input int gap);
		int n;
		lat = 0;
		@(posedge clock);
		req_valid <= 1'b1;
		// Manufacturer code and UID are checked before this port
		req <= '{op, opt, sec, ml, mv, prm};
		@(posedge clock);
		req_valid <= 1'b0;
		// Stale fields must never be mistaken for a fresh request
		req <= eas_pkg::req_s'(~req);
		// A one-cycle reply launched at the take edge is seen first
		for (n = 1; n <= 40; n++) begin
			@(negedge clock);
			if (resp_valid === 1'b1) begin
				lat = n;
				got = resp;
				break;
			end
			@(posedge clock);
			eof_pulse <= opt && op != 8'hA5 && n == gap;
		end
	endtask
endmodule
`default_nettype wire

//--- eas_custom_command_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, seen) \
	begin \
		check_count++; \
		if ((seen) !== (exp)) begin \
			bad_count++; \
			$display("wrong value %s expected %h seen %h", what, exp, seen); \
		end \
	end
module eas_custom_command_handler_test;
	// Short programming time keeps the run brief
	localparam int PROG = 4;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid, eof_pulse, resp_valid, avs_waitrequest;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	eas_pkg::req_s req;
	eas_pkg::resp_s resp;
	logic [3:0] avs_address = 4'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic [31:0] tele [8];
	int bad_count = 0;
	int check_count = 0;
	int i;
	always #20 clock = ~clock;
	eas_custom_command_handler #(.PROG_CYCLES(PROG)) DUT (.clock(clock),
		.rst_b(rst_b), .req_valid(req_valid), .req(req),
		.eof_pulse(eof_pulse), .resp_valid(resp_valid), .resp(resp),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	eas_reader_model rdr (.clock(clock), .req_valid(req_valid), .req(req),
		.eof_pulse(eof_pulse), .resp_valid(resp_valid), .resp(resp));
	task automatic give_verdict;
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// Only the watchdog ends a wait that never sees an answer
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		`CHK("register", e, rd)
	endtask
	// A nonzero code means the request should be refused with that code
	task automatic cmd(input logic [7:0] op, input logic opt, input logic sec,
		input logic [15:0] prm, input int gap, input int elat,
		input logic [7:0] code);
		rdr.send(op, opt, sec, 8'h00, 16'h0000, prm, gap);
		`CHK("latency", elat, rdr.lat)
		if (code == 8'h00)
			`CHK("flags", eas_pkg::FLAGS_OK, rdr.got.flags)
		else
			`CHK("flags", eas_pkg::FLAGS_ERROR, rdr.got.flags)
		if (code != 8'h00)
			`CHK("code", code, rdr.got.code)
	endtask
	task automatic act(input logic opt, input logic [7:0] ml,
		input logic [15:0] mv, input int elat);
		rdr.send(8'hA5, opt, 1'b0, ml, mv, 16'h0000, 12);
		`CHK("latency", elat, rdr.lat)
		if (elat != 0)
			`CHK("flags", eas_pkg::FLAGS_OK, rdr.got.flags)
	endtask
	task automatic tele_chk(input int sel);
		int k;
		int b;
		b = 8 - (8 >> sel);
		act(1'b0, 8'h55, 16'hFFFF, 1);
		`CHK("kind", eas_pkg::RESP_TELEGRAM, rdr.got.kind)
		`CHK("bits", 9'(256 >> sel), rdr.got.bits)
		for (k = 0; k < (8 >> sel); k++) begin
			`CHK("word", tele[b + k], rdr.got.payload[32*k +: 32])
		end
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		rdchk(eas_pkg::REG_STATUS, 32'h0);
		rdchk(eas_pkg::REG_IDENT, 32'h0);
		for (i = 0; i < 8; i++) begin
			rdchk(eas_pkg::REG_TELE_BASE + 4'(i), 32'h0);
			tele[i] = 32'hC0DE0000 | (32'h111 * i);
			bus(1'b1, eas_pkg::REG_TELE_BASE + 4'(i), tele[i], 4'hF);
		end
		rdchk(4'hA, 32'h0);
		bus(1'b1, eas_pkg::REG_TELE_LAST, 32'hFFFFFFFF, 4'h2);
		tele[7][15:8] = 8'hFF;
		act(1'b0, 8'h00, 16'h0000, 0);
		cmd(8'hA2, 1'b0, 1'b0, 16'h0, 12, PROG + 1, 8'h00);
		rdchk(eas_pkg::REG_STATUS, 32'h1);
		tele_chk(0);
		for (i = 0; i < 4; i++) begin
			cmd(8'hA8, 1'b1, 1'b0, 16'hFC | i, 5 + i, 7 + i, 8'h00);
			rdchk(eas_pkg::REG_STATUS, 32'h1 | (i << 4));
			tele_chk(i);
		end
		cmd(8'hA8, 1'b0, 1'b0, 16'hFF00, 12, PROG + 1, 8'h00);
		act(1'b1, eas_pkg::MASK_WORD, 16'h0000, 1);
		act(1'b1, eas_pkg::MASK_BYTE, 16'h0001, 0);
		act(1'b1, eas_pkg::MASK_NONE, 16'h0000, 1);
		`CHK("kind", eas_pkg::RESP_IDENT, rdr.got.kind)
		`CHK("ident", 16'h0000, rdr.got.payload[15:0])
		act(1'b1, 8'h18, 16'h0000, 0);
		cmd(8'hA6, 1'b0, 1'b0, 16'h0, 12, 1, eas_pkg::ERR_NOT_SECURE);
		cmd(8'hA6, 1'b1, 1'b1, 16'h0, 12, 14, 8'h00);
		rdchk(eas_pkg::REG_STATUS, 32'h5);
		cmd(8'hA7, 1'b0, 1'b0, 16'hBEEF, 12, 1, eas_pkg::ERR_NOT_SECURE);
		cmd(8'hA7, 1'b0, 1'b1, 16'hBEEF, 12, PROG + 1, 8'h00);
		rdchk(eas_pkg::REG_IDENT, 32'h0000BEEF);
		cmd(8'hA8, 1'b0, 1'b0, 16'h3, 12, 1, eas_pkg::ERR_NOT_SECURE);
		act(1'b1, eas_pkg::MASK_BYTE, 16'h12EF, 1);
		act(1'b1, eas_pkg::MASK_WORD, 16'h12EF, 0);
		cmd(8'hA4, 1'b0, 1'b0, 16'h0, 12, 1, eas_pkg::ERR_NOT_SECURE);
		cmd(8'hA4, 1'b0, 1'b1, 16'h0, 12, PROG + 1, 8'h00);
		rdchk(eas_pkg::REG_STATUS, 32'h7);
		cmd(8'hA3, 1'b0, 1'b1, 16'h0, 12, 1, eas_pkg::ERR_LOCKED);
		cmd(8'hA2, 1'b1, 1'b1, 16'h0, 12, 1, eas_pkg::ERR_LOCKED);
		cmd(8'hA7, 1'b0, 1'b1, 16'h1234, 12, 1, eas_pkg::ERR_LOCKED);
		rdchk(eas_pkg::REG_IDENT, 32'h0000BEEF);
		rdchk(eas_pkg::REG_STATUS, 32'h7);
		give_verdict();
	end
endmodule
`default_nettype wire
